// ==== hspc_defs.vh ====
// Constants for the host serial port configuration block
`ifndef HSPC_DEFS_VH
`define HSPC_DEFS_VH
`define HSPC_SEL_SLAVE 2'h0
`define HSPC_SEL_MASTER 2'h3
`define HSPC_SEL_RESET 2'h0
`define HSPC_ADDR_BASE 7'h50
`define HSPC_CLK_HZ 25000000
`define HSPC_SCL_HZ 100000
`define HSPC_SCL_HALF ((`HSPC_CLK_HZ / `HSPC_SCL_HZ) / 2)
`define HSPC_ROM_ADDR 7'h50
`define HSPC_ROM_BYTES 8
`endif

// ==== hspc_top.v ====
// Host serial port pin logic: mode straps, slave address, EEPROM master, interrupt pin
`timescale 1ns/1ps
`include "hspc_defs.vh"

// Notes on behaviour
// - Mode straps sampled while reset active, loaded as host port select bits.
// - Select 00 means serial slave; codes 01 and 10 are reserved.
// - Select 11 makes device bus master, loading configuration from EEPROM.
// - Master mode: upper strap pin drives the bus clock out.
// - Master mode: lower strap pin is open-drain data, driven low and sampled.
// - Slave mode: address bits 2 and 1 come from the address straps.
// - Slave mode: data pin shared open-drain, each side only pulls low.
// - Device provides an open-drain interrupt request output pin.
module hspc_top #(
    parameter SCL_HALF = `HSPC_SCL_HALF,
    parameter ROM_BYTES = `HSPC_ROM_BYTES
) (
    // Clock and reset
    input wire i_mclk,
    input wire i_rst,
    // Mode strap pins, reused in master mode
    input wire i_mode1,
    output reg o_mode1,
    output reg o_mode1_oe_n,
    input wire i_mode0,
    output reg o_mode0,
    output reg o_mode0_oe_n,
    // Address straps
    input wire i_addr2,
    input wire i_addr1,
    // Slave bus pins
    input wire i_slave_scl,
    input wire i_slave_sda,
    output reg o_slave_sda,
    output reg o_slave_sda_oe_n,
    // Slave-side pull request from the register core
    input wire i_slave_pull_low,
    // Interrupt
    input wire i_event_pending,
    input wire i_event_enable,
    output reg o_int_req,
    output reg o_int_req_oe_n,
    // Status toward the core
    output reg [1:0] o_sel,
    output reg [6:0] o_slave_addr,
    output reg o_slave_scl,
    output reg o_slave_sda_in,
    output reg o_cfg_valid,
    output reg [7:0] o_cfg_data,
    output reg o_cfg_done,
    output reg o_cfg_error
);
    localparam ST_IDLE = 3'h0;
    localparam ST_START = 3'h1;
    localparam ST_BIT = 3'h2;
    localparam ST_STOP = 3'h3;
    localparam ST_DONE = 3'h4;

    // Two-stage synchronisers; only stage two is read
    reg [5:0] sync1;
    reg [5:0] sync2;
    always @(posedge i_mclk) begin
        sync1 <= {i_mode1, i_mode0, i_addr2, i_addr1, i_slave_scl, i_slave_sda};
        sync2 <= sync1;
    end
    wire s_mode1 = sync2[5];
    wire s_mode0 = sync2[4];
    // Base address kept as a named vector so only its upper four bits are taken
    wire [6:0] addr_base = `HSPC_ADDR_BASE;

    // Straps tracked throughout reset, frozen at release
    always @(posedge i_mclk) begin
        if (i_rst) begin
            o_sel <= {s_mode1, s_mode0};
            o_slave_addr <= {addr_base[6:3], sync2[3], sync2[2], 1'b0};
        end
    end
    wire is_master = (o_sel == `HSPC_SEL_MASTER);
    wire is_slave = (o_sel == `HSPC_SEL_SLAVE);

    // Slave path: clock pin is input only, data pulled low or released
    always @(posedge i_mclk) begin
        if (i_rst) begin
            o_slave_scl <= 1'b1;
            o_slave_sda_in <= 1'b1;
            o_slave_sda <= 1'b0;
            o_slave_sda_oe_n <= 1'b1;
        end else begin
            o_slave_scl <= sync2[1];
            o_slave_sda_in <= sync2[0];
            o_slave_sda <= 1'b0;
            o_slave_sda_oe_n <= ~(is_slave & i_slave_pull_low);
        end
    end

    // EEPROM reader: start, address, read bytes with ack, nack last, stop
    reg [2:0] state;
    reg [15:0] tick;
    reg [1:0] phase;
    reg [3:0] bitn;
    reg [7:0] shreg;
    reg addr_phase;
    reg [7:0] nbytes;
    reg scl_drv;
    reg sda_low;
    localparam [31:0] TICK_LAST = SCL_HALF - 1;
    localparam [31:0] BYTE_LAST = ROM_BYTES - 1;
    // Counters are widened rather than the limits cut, so a large setting cannot alias
    wire tick_end = ({16'h0000, tick} == TICK_LAST);
    wire last_byte = ({24'h000000, nbytes} == BYTE_LAST);
    always @(posedge i_mclk) begin
        if (i_rst) begin
            state <= ST_IDLE;
            tick <= 16'h0000;
            phase <= 2'h0;
            bitn <= 4'h0;
            shreg <= 8'h00;
            addr_phase <= 1'b1;
            nbytes <= 8'h00;
            scl_drv <= 1'b1;
            sda_low <= 1'b0;
            o_cfg_valid <= 1'b0;
            o_cfg_data <= 8'h00;
            o_cfg_done <= 1'b0;
            o_cfg_error <= 1'b0;
        end else begin
            o_cfg_valid <= 1'b0;
            tick <= tick_end ? 16'h0000 : tick + 16'h0001;
            case (state)
                ST_IDLE: begin
                    if (is_master && tick_end) begin
                        sda_low <= 1'b1;
                        state <= ST_START;
                    end
                end
                ST_START: begin
                    if (tick_end) begin
                        scl_drv <= 1'b0;
                        shreg <= {`HSPC_ROM_ADDR, 1'b1};
                        bitn <= 4'h0;
                        phase <= 2'h0;
                        state <= ST_BIT;
                    end
                end
                ST_BIT: begin
                    if (tick_end) begin
                        phase <= phase + 2'h1;
                        if (phase == 2'h0) begin
                            // Data changes while the clock is low
                            if (bitn < 4'h8)
                                sda_low <= addr_phase ? ~shreg[7] : 1'b0;
                            else
                                sda_low <= ~addr_phase & ~last_byte;
                        end else if (phase == 2'h1) begin
                            scl_drv <= 1'b1;
                        end else begin
                            scl_drv <= 1'b0;
                            phase <= 2'h0;
                            if (bitn < 4'h8) begin
                                shreg <= {shreg[6:0], s_mode0};
                                bitn <= bitn + 4'h1;
                            end else begin
                                bitn <= 4'h0;
                                if (addr_phase) begin
                                    addr_phase <= 1'b0;
                                    if (s_mode0) begin
                                        o_cfg_error <= 1'b1;
                                        state <= ST_STOP;
                                    end
                                end else begin
                                    o_cfg_valid <= 1'b1;
                                    o_cfg_data <= shreg;
                                    nbytes <= nbytes + 8'h01;
                                    if (last_byte)
                                        state <= ST_STOP;
                                end
                            end
                        end
                    end
                end
                ST_STOP: begin
                    if (tick_end) begin
                        phase <= phase + 2'h1;
                        if (phase == 2'h0)
                            sda_low <= 1'b1;
                        else if (phase == 2'h1)
                            scl_drv <= 1'b1;
                        else begin
                            sda_low <= 1'b0;
                            state <= ST_DONE;
                        end
                    end
                end
                ST_DONE: begin
                    o_cfg_done <= 1'b1;
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // Strap pins stay released outside master mode so the straps read true
    always @(posedge i_mclk) begin
        if (i_rst) begin
            o_mode1 <= 1'b1;
            o_mode1_oe_n <= 1'b1;
            o_mode0 <= 1'b0;
            o_mode0_oe_n <= 1'b1;
        end else begin
            o_mode1 <= scl_drv;
            o_mode1_oe_n <= ~is_master;
            o_mode0 <= 1'b0;
            o_mode0_oe_n <= ~(is_master & sda_low);
        end
    end

    // Interrupt pin driven low only while an enabled event pends
    always @(posedge i_mclk) begin
        if (i_rst) begin
            o_int_req <= 1'b0;
            o_int_req_oe_n <= 1'b1;
        end else begin
            o_int_req <= 1'b0;
            o_int_req_oe_n <= ~(i_event_pending & i_event_enable);
        end
    end
endmodule // hspc_top

// ==== hspc_chk.sv ====
// Assertion checker for the host serial port pin logic
`timescale 1ns/1ps
module hspc_chk (
    // Clock, reset and stimulus
    input wire i_mclk,
    input wire i_rst,
    input wire i_slave_pull_low,
    input wire i_event_pending,
    input wire i_event_enable,
    // Pin enables and status
    input wire o_mode1_oe_n,
    input wire o_mode0_oe_n,
    input wire o_slave_sda,
    input wire o_slave_sda_oe_n,
    input wire o_int_req,
    input wire o_int_req_oe_n,
    input wire [1:0] o_sel,
    input wire o_cfg_valid,
    input wire o_cfg_done
);
    // One domain; nothing is judged while reset holds
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_rst);
    sel_frozen_a: assert property (!$past(i_rst) |-> $stable(o_sel)) else $error("select moved");
    reserved_idle_a: assert property ((o_sel == 2'h1 || o_sel == 2'h2) |->
        o_mode1_oe_n && o_mode0_oe_n && !o_cfg_valid) else $error("reserved code active");
    slave_idle_a: assert property (o_sel != 2'h3 |-> o_mode1_oe_n && o_mode0_oe_n) else $error("strap pin driven");
    done_hold_a: assert property (o_cfg_done |=> o_cfg_done) else $error("done dropped");
    valid_pulse_a: assert property (o_cfg_valid |=> !o_cfg_valid) else $error("valid too long");
    slave_pull_a: assert property (o_sel == 2'h0 && i_slave_pull_low |=>
        !o_slave_sda_oe_n && !o_slave_sda) else $error("slave pull missing");
    slave_free_a: assert property (!i_slave_pull_low |=> o_slave_sda_oe_n) else $error("slave data held");
    int_drive_a: assert property (i_event_pending && i_event_enable |=>
        !o_int_req_oe_n && !o_int_req) else $error("interrupt not driven");
    int_free_a: assert property (!(i_event_pending && i_event_enable) |=> o_int_req_oe_n) else $error("interrupt held");
endmodule // hspc_chk

// ==== hspc_rom_model.sv ====
// Behavioural serial EEPROM answering the configuration fetch
`timescale 1ns/1ps
module hspc_rom_model (
    // Board wires
    input wire i_scl,
    input wire i_sda,
    // High pulls the data wire low
    output reg o_pull
);
    reg active = 1'b0;
    reg [3:0] cnt = 4'h0;
    reg [3:0] byte_n = 4'h0;
    reg [7:0] rom_byte = 8'h00;
    reg scl_q = 1'b1;
    reg sda_q = 1'b1;
    initial o_pull = 1'b0;
    // One process watches both wires so every variable has a single writer
    always @(i_scl or i_sda) begin
        if (i_scl === 1'b1 && scl_q === 1'b1 && sda_q === 1'b1 && i_sda === 1'b0) begin
            // Start: data falls while the clock is high
            active = 1'b1;
            cnt = 4'h0;
            byte_n = 4'h0;
        end else if (i_scl === 1'b1 && scl_q === 1'b1 && sda_q === 1'b0 && i_sda === 1'b1) begin
            // Stop: data rises while the clock is high
            active = 1'b0;
        end else if (i_scl === 1'b1 && scl_q !== 1'b1) begin
            // A released acknowledge after a data byte ends the read
            cnt = cnt + 4'h1;
            if (cnt == 4'h9 && byte_n != 4'h0 && i_sda === 1'b1)
                active = 1'b0;
        end else if (i_scl !== 1'b1 && scl_q === 1'b1) begin
            if (cnt == 4'h9) begin
                cnt = 4'h0;
                byte_n = byte_n + 4'h1;
            end
            // Byte is rebuilt here, after the count moves, so no bit uses a stale value
            rom_byte = {byte_n, ~byte_n};
            // Output changes late after the clock falls, like a real access delay
            if (!active)
                o_pull <= #100 1'b0;
            else if (cnt == 4'h8)
                o_pull <= #100 (byte_n == 4'h0);
            else
                o_pull <= #100 (byte_n != 4'h0) && !rom_byte[3'h7 - cnt[2:0]];
        end
        scl_q = i_scl;
        sda_q = i_sda;
    end
endmodule // hspc_rom_model

// ==== tb_top.sv ====
// Self-checking testbench for the host serial port pin logic
`timescale 1ns/1ps
module tb_top;
    reg i_mclk = 0;
    reg i_rst = 1;
    reg [1:0] strap = 0;
    reg i_addr2 = 0;
    reg i_addr1 = 0;
    reg i_slave_scl = 0;
    reg i_slave_pull_low = 0;
    reg i_event_pending = 0;
    reg i_event_enable = 0;
    integer failures = 0;
    integer num_checks = 0;
    integer k;
    integer n;
    wire o_mode1, o_mode1_oe_n, o_mode0, o_mode0_oe_n, o_slave_sda, o_slave_sda_oe_n, o_int_req, o_int_req_oe_n;
    wire o_slave_scl, o_slave_sda_in, o_cfg_valid, o_cfg_done, o_cfg_error, rom_pull;
    wire [1:0] o_sel;
    wire [6:0] o_slave_addr;
    wire [7:0] o_cfg_data;
    // Released strap pins rest at the board level; the EEPROM shares the data wire
    wire scl_w = o_mode1_oe_n ? strap[1] : o_mode1;
    wire sda_w = strap[0] & (o_mode0_oe_n | o_mode0) & ~rom_pull;
    hspc_top #(.SCL_HALF(4), .ROM_BYTES(8)) u_hspc_top (.*, .i_mode1(scl_w), .i_mode0(sda_w),
        .i_slave_sda(o_slave_sda_oe_n | o_slave_sda));
    hspc_rom_model u_hspc_rom_model (.i_scl(scl_w), .i_sda(sda_w), .o_pull(rom_pull));
    // System clock and the unrelated host bus clock
    initial forever #20 i_mclk = ~i_mclk;
    always #160 i_slave_scl = ~i_slave_scl;
    task chk(input [7:0] got, input [7:0] exp);
        begin
            num_checks = num_checks + 1;
            if (got !== exp) begin
                failures = failures + 1;
                $display("ERROR %0t got %h exp %h", $time, got, exp);
            end
        end
    endtask
    // Straps are set with reset, as the board would hold them
    task start(input [1:0] s, input a2, input a1);
        begin
            @(negedge i_mclk);
            i_rst = 1;
            strap = s;
            i_addr2 = a2;
            i_addr1 = a1;
            repeat (3) @(negedge i_mclk);
            i_rst = 0;
        end
    endtask
    task t_slave;
        begin
            start(2'h0, 1'b1, 1'b0);
            chk(o_sel, 8'h00);
            chk(o_slave_addr, 8'h54);
            i_slave_pull_low = 1;
            @(negedge i_mclk);
            chk({o_mode1_oe_n, o_slave_sda_oe_n}, 8'h02);
            i_event_pending = 1;
            @(negedge i_mclk);
            chk(o_int_req_oe_n, 8'h01);
            i_event_enable = 1;
            @(negedge i_mclk);
            chk({o_int_req_oe_n, o_int_req}, 8'h00);
            i_event_pending = 0;
            chk(o_slave_sda, 8'h00);
            // Host clock moves on falling edges; look well after the three-flop delay
            @(posedge i_slave_scl);
            #130;
            chk({o_slave_scl, o_slave_sda_in}, 8'h02);
            #160;
            chk({o_slave_scl, o_slave_sda_in}, 8'h00);
        end
    endtask
    task t_reserved;
        for (k = 1; k <= 2; k = k + 1) begin
            start(k[1:0], 1'b0, 1'b0);
            chk(o_sel, k[7:0]);
            repeat (40) @(negedge i_mclk);
            chk({o_cfg_done, o_mode1_oe_n, o_mode0_oe_n}, 8'h03);
        end
    endtask
    // Bounded waits: a missing byte shows up as a data mismatch
    task t_master;
        begin
            start(2'h3, 1'b0, 1'b0);
            for (k = 1; k <= 8; k = k + 1) begin
                for (n = 0; n < 2000 && o_cfg_valid !== 1'b1; n = n + 1) @(negedge i_mclk);
                chk(o_cfg_valid, 8'h01);
                chk(o_cfg_data, {k[3:0], ~k[3:0]});
                @(negedge i_mclk);
            end
            for (n = 0; n < 500 && o_cfg_done !== 1'b1; n = n + 1) @(negedge i_mclk);
            chk({o_cfg_done, o_cfg_error, o_slave_sda_oe_n}, 8'h05);
        end
    endtask
    task finish_test;
        begin
            if (failures == 0 && num_checks > 0) $display("ALL CHECKS OK");
            else $display("CHECKS NOT OK");
            $finish;
        end
    endtask
    // Watchdog well beyond the roughly 1100 cycles the tests need
    initial begin
        #1000000;
        failures = failures + 1;
        finish_test;
    end
    initial begin
        t_slave;
        t_reserved;
        t_master;
        finish_test;
    end
endmodule // tb_top
bind hspc_top hspc_chk u_hspc_chk (.i_mclk(i_mclk), .i_rst(i_rst), .i_slave_pull_low(i_slave_pull_low),
    .i_event_pending(i_event_pending), .i_event_enable(i_event_enable), .o_mode1_oe_n(o_mode1_oe_n),
    .o_mode0_oe_n(o_mode0_oe_n), .o_slave_sda(o_slave_sda), .o_slave_sda_oe_n(o_slave_sda_oe_n),
    .o_int_req(o_int_req), .o_int_req_oe_n(o_int_req_oe_n), .o_sel(o_sel), .o_cfg_valid(o_cfg_valid),
    .o_cfg_done(o_cfg_done));
